// ---- bench/icm_irq_ctrl_props.sv ----
// assertion checker for the iso context interrupt block
`timescale 1ns/10ps
module icm_irq_ctrl_props
   import icm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ICM_ADDR_W-1:0] paddr,
   input wire logic [ICM_DATA_W-1:0] pwdata,
   input wire logic [ICM_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [ICM_TX_N-1:0] tx_ctx_irq,
   input wire logic [ICM_RX_N-1:0] rx_ctx_irq,
   input wire logic [ICM_RX_N-1:0] rx_irq_mask,
   input wire logic [ICM_DATA_W-1:0] main_irq_mask,
   input wire logic aggregate_tx_ctx_event,
   input wire logic aggregate_rx_ctx_event,
   input wire logic irq_req
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // access-phase decodes
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire mapped = paddr inside {8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4};
   wire tx_clr = wr && (paddr == 8'h94 || paddr == 8'h9c);
   wire rx_clr = wr && paddr == 8'ha4;
   wire tx_go = aggregate_tx_ctx_event && main_irq_mask[6];
   wire rx_go = aggregate_rx_ctx_event && main_irq_mask[7];
   // a cause worth a request this cycle, kept as one net for the history check
   wire irq_cause = main_irq_mask[31] && (tx_go || rx_go);
   ////////////////////////////////////////////////////////////////
   a_ready_const: assert property (pready) else $error("wait state seen");
   a_unmapped_err: assert property (acc |-> pslverr == !mapped) else $error("slave error wrong");
   a_tx_rsvd_zero: assert property (rd && paddr[7:4] == 4'h9 |-> prdata[31:8] == 24'h0)
      else $error("tx upper bits set");
   a_rx_rsvd_zero: assert property (rd && paddr[7:4] == 4'ha |-> prdata[31:4] == 28'h0)
      else $error("rx upper bits set");
   a_tx_sticky: assert property (aggregate_tx_ctx_event && !tx_clr |=> aggregate_tx_ctx_event)
      else $error("tx aggregate dropped");
   a_rx_sticky: assert property (aggregate_rx_ctx_event && !rx_clr ##1 $stable(rx_irq_mask)
      |-> aggregate_rx_ctx_event) else $error("rx aggregate dropped");
   a_rx_edge_set: assert property ((rx_irq_mask & rx_ctx_irq & ~$past(rx_ctx_irq)) != 4'h0
      ##1 $stable(rx_irq_mask) |-> aggregate_rx_ctx_event) else $error("rx edge lost");
   a_irq_cause: assert property (irq_req |-> $past(irq_cause))
      else $error("request without cause");
   a_irq_raise: assert property (main_irq_mask[31] && (tx_go || rx_go) |=> irq_req)
      else $error("request missing");
   c_irq: cover property ($rose(irq_req));
   c_err: cover property (acc && pslverr);
   c_tx_clr: cover property (aggregate_tx_ctx_event && tx_clr);
endmodule
bind icm_irq_ctrl icm_irq_ctrl_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .tx_ctx_irq, .rx_ctx_irq, .rx_irq_mask, .main_irq_mask,
   .aggregate_tx_ctx_event, .aggregate_rx_ctx_event, .irq_req);

// ---- bench/icm_irq_ctrl_tb_top.sv ----
// self-checking bench for the iso context interrupt block
`timescale 1ns/10ps
module icm_irq_ctrl_tb_top;
   import icm_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, tx_ctx_irq = 8'h00;
   logic [31:0] pwdata = 32'h0, main_irq_mask = 32'h0, prdata;
   logic [3:0] rx_ctx_irq = 4'h0, rx_irq_mask = 4'h0;
   logic pready, pslverr, aggregate_tx_ctx_event, aggregate_rx_ctx_event, irq_req;
   int bad_count = 0, n_compared = 0;
   // reference state: events, tx mask, line history, request
   int tev, tmk, rev, tp, rp, irq_m;
   // register map plus one unmapped offset at the end
   logic [7:0] amap [7] = '{8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0, 8'ha4, 8'h80};
   icm_irq_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .tx_ctx_irq, .rx_ctx_irq, .rx_irq_mask, .main_irq_mask, .aggregate_tx_ctx_event,
      .aggregate_rx_ctx_event, .irq_req);
   initial forever #25 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////
   // model: clears are applied before sets, so a set wins
   always @(posedge pclk or negedge presetn) begin
      int ts, rs, w;
      if (!presetn) begin
         {tev, tmk, rev, tp, rp, irq_m} <= '0;
      end else begin
         w = psel && penable && pwrite;
         ts = tx_ctx_irq & ~tp;
         rs = rx_ctx_irq & ~rp;
         if (w && paddr == 8'h90) ts |= pwdata[7:0];
         if (w && paddr == 8'ha0) rs |= pwdata[3:0];
         tp <= tx_ctx_irq;
         rp <= rx_ctx_irq;
         tev <= tev & ~(w && paddr == 8'h94 ? int'(pwdata[7:0]) : 0) | ts;
         rev <= rev & ~(w && paddr == 8'ha4 ? int'(pwdata[3:0]) : 0) | rs;
         tmk <= w && paddr == 8'h98 ? tmk | pwdata[7:0] : w && paddr == 8'h9c ? tmk & ~pwdata[7:0] : tmk;
         irq_m <= main_irq_mask[31] && ((|(tev & tmk) && main_irq_mask[6]) ||
            (|(rev & rx_irq_mask) && main_irq_mask[7]));
      end
   end
   // expected read data for an offset
   function automatic int exp_rd(logic [7:0] a);
      case (a)
         8'h90: return tev;
         8'h94: return tev & tmk;
         8'h98, 8'h9c: return tmk;
         8'ha0: return rev;
         8'ha4: return rev & rx_irq_mask;
         default: return 0;
      endcase
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // one apb transfer; the request stays up so a setup may follow at once
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
      int k;
      logic [31:0] e;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      e = exp_rd(a);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k == 50) bad_count++;
      if (!w) chk("read data", e, prdata);
      chk("slave error", a == 8'h80, pslverr);
   endtask
   // aggregates and request checked every cycle, away from the edge
   always @(negedge pclk) begin
      if (presetn) begin
         chk("tx aggregate", |(tev & tmk), aggregate_tx_ctx_event);
         chk("rx aggregate", |(rev & rx_irq_mask), aggregate_rx_ctx_event);
         chk("irq request", irq_m, irq_req);
      end
   end
   task automatic tally_and_finish;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // hang guard, well beyond the ~900 cycles the run needs
   initial begin
      #(50 * 6000);
      bad_count++;
      tally_and_finish;
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h3687712e));
      repeat (16) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      foreach (amap[i]) xfer(0, amap[i], 32'h0);
      // software clears stale events and programs the tx mask first
      xfer(1, 8'h94, 32'hff);
      xfer(1, 8'ha4, 32'hf);
      xfer(1, 8'h98, 32'hff);
      // bus goes idle while context lines rise and the request builds up
      psel <= 0;
      penable <= 0;
      main_irq_mask <= 32'h800000c0;
      rx_irq_mask <= 4'hf;
      tx_ctx_irq <= 8'h24;
      rx_ctx_irq <= 4'h5;
      repeat (3) @(posedge pclk);
      // software finds the causing contexts, acknowledges them; held lines stay quiet
      xfer(0, 8'h94, 32'h0);
      xfer(0, 8'ha4, 32'h0);
      xfer(1, 8'h94, 32'h24);
      xfer(1, 8'ha4, 32'h5);
      xfer(0, 8'h90, 32'h0);
      xfer(0, 8'ha0, 32'h0);
      // random back-to-back traffic with line edges and mask moves
      for (int i = 0; i < 400; i++) begin
         tx_ctx_irq <= 8'($urandom);
         rx_ctx_irq <= 4'($urandom);
         rx_irq_mask <= 4'($urandom);
         main_irq_mask <= $urandom;
         xfer(1'($urandom), amap[$urandom % 7], $urandom);
         if (i == 200) begin
            presetn <= 0;
            psel <= 0;
            penable <= 0;
            @(posedge pclk);
            presetn <= 1;
         end
      end
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
      tally_and_finish;
   end
endmodule

// ---- verilog/icm_event_bank.sv ----
// sticky per-context event bits with edge detect and set/clear
`timescale 1ns/10ps
module icm_event_bank #(
   parameter int N = 8,
   parameter logic [N-1:0] RST = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   icm_evt_if.bank ev
);

   logic [N-1:0] irq_prev_r; // last sampled context lines
   logic [N-1:0] event_r;    // sticky event state
   logic [N-1:0] rise;       // asserting edges this cycle
   logic [N-1:0] event_nxt;

   // lines come from same-clock dma logic, so no synchroniser
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_prev_r <= '0;
      end else begin
         irq_prev_r <= ev.ctx_irq;
      end
   end

   // only the edge counts; a held line does not re-raise a cleared bit
   assign rise = ev.ctx_irq & ~irq_prev_r;

   // set terms win over a clear in the same cycle
   always_comb begin
      event_nxt = (event_r & ~ev.clr_bits) | rise | ev.set_bits;
   end

   // event state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_r <= RST;
      end else begin
         event_r <= event_nxt;
      end
   end

   assign ev.event_q = event_r;
   assign ev.masked = event_r & ev.mask;
   assign ev.any = |(event_r & ev.mask);
endmodule

// ---- verilog/icm_evt_if.sv ----
// bundle between the register front end and one event bank
`timescale 1ns/10ps
interface icm_evt_if #(parameter int N = 8);
   logic [N-1:0] ctx_irq;   // context interrupt lines
   logic [N-1:0] set_bits;  // one-cycle set requests from software
   logic [N-1:0] clr_bits;  // one-cycle clear requests from software
   logic [N-1:0] mask;      // per-context enables
   logic [N-1:0] event_q;   // sticky event state
   logic [N-1:0] masked;    // event and mask
   logic any;               // or of masked bits

   // the bank owns the event state
   modport bank (input ctx_irq, input set_bits, input clr_bits, input mask,
                 output event_q, output masked, output any);
   // the front end drives requests and reads state
   modport front (output ctx_irq, output set_bits, output clr_bits, output mask,
                  input event_q, input masked, input any);
endinterface

// ---- verilog/icm_irq_ctrl.sv ----
// apb front end for iso context interrupt event and mask registers
//
// Local design decision: register access over APB.
`timescale 1ns/10ps
module icm_irq_ctrl
   import icm_pkg::*;
(
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ICM_ADDR_W-1:0] paddr,
   input wire logic [ICM_DATA_W-1:0] pwdata,
   output logic [ICM_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // context interrupt lines, same clock
   input wire logic [ICM_TX_N-1:0] tx_ctx_irq,
   input wire logic [ICM_RX_N-1:0] rx_ctx_irq,
   // rx mask kept elsewhere
   input wire logic [ICM_RX_N-1:0] rx_irq_mask,
   // main interrupt mask word
   input wire logic [ICM_DATA_W-1:0] main_irq_mask,
   // aggregate bits toward the main event register
   output logic aggregate_tx_ctx_event,
   output logic aggregate_rx_ctx_event,
   // interrupt request
   output logic irq_req
);

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // address to one-hot register select
   function automatic icm_sel_t icm_decode(input logic [ICM_ADDR_W-1:0] a);
      icm_sel_t s;
      s = ICM_SEL_NONE;
      unique case (a)
         ICM_TX_EVT_SET_OFS: s = ICM_SEL_TX_EVT_SET;
         ICM_TX_EVT_CLR_OFS: s = ICM_SEL_TX_EVT_CLR;
         ICM_TX_MSK_SET_OFS: s = ICM_SEL_TX_MSK_SET;
         ICM_TX_MSK_CLR_OFS: s = ICM_SEL_TX_MSK_CLR;
         ICM_RX_EVT_SET_OFS: s = ICM_SEL_RX_EVT_SET;
         ICM_RX_EVT_CLR_OFS: s = ICM_SEL_RX_EVT_CLR;
         default: s = ICM_SEL_NONE; // unmapped
      endcase
      return s;
   endfunction

   // widen a tx-sized field to a bus word, upper bits zero
   function automatic logic [ICM_DATA_W-1:0] icm_tx_word(input logic [ICM_TX_N-1:0] v);
      return {{(ICM_DATA_W-ICM_TX_N){1'b0}}, v};
   endfunction

   // widen an rx-sized field to a bus word, upper bits zero
   function automatic logic [ICM_DATA_W-1:0] icm_rx_word(input logic [ICM_RX_N-1:0] v);
      return {{(ICM_DATA_W-ICM_RX_N){1'b0}}, v};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // declarations

   icm_evt_if #(.N(ICM_TX_N)) tx_ev(); // tx event bank link
   icm_evt_if #(.N(ICM_RX_N)) rx_ev(); // rx event bank link

   icm_sel_t sel;                        // decoded select
   logic setup_ph;                       // apb setup cycle
   logic access_ph;                      // apb access cycle
   logic wr_go;                          // write commits this edge
   logic [ICM_TX_N-1:0] tx_mask_r;       // tx mask state
   logic [ICM_TX_N-1:0] tx_mask_nxt;
   logic [ICM_DATA_W-1:0] prdata_r;      // read data staged in setup
   logic [ICM_DATA_W-1:0] rd_word;       // read mux output
   logic irq_req_r;                      // registered request
   logic irq_req_nxt;

   ////////////////////////////////////////////////////////////////////////
   // apb phase tracking

   // the slave never stalls: read data is staged during setup
   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable;
   assign sel = icm_decode(paddr);
   assign wr_go = access_ph & pwrite & (sel != ICM_SEL_NONE);

   // zero wait states on every access
   assign pready = 1'b1;

   // unmapped offsets error out, both for reads and writes
   assign pslverr = access_ph & (sel == ICM_SEL_NONE);

   ////////////////////////////////////////////////////////////////////////
   // write strobes toward the event banks

   // tx set strobes, one-cycle; writing zero does nothing
   always_comb begin
      tx_ev.set_bits = '0;
      if (wr_go && sel == ICM_SEL_TX_EVT_SET) begin
         tx_ev.set_bits = pwdata[ICM_TX_N-1:0];
      end
   end

   // tx clear strobes; only ones clear
   always_comb begin
      tx_ev.clr_bits = '0;
      if (wr_go && sel == ICM_SEL_TX_EVT_CLR) begin
         tx_ev.clr_bits = pwdata[ICM_TX_N-1:0];
      end
   end

   // rx set strobes, upper write bits dropped
   always_comb begin
      rx_ev.set_bits = '0;
      if (wr_go && sel == ICM_SEL_RX_EVT_SET) begin
         rx_ev.set_bits = pwdata[ICM_RX_N-1:0];
      end
   end

   // rx clear strobes
   always_comb begin
      rx_ev.clr_bits = '0;
      if (wr_go && sel == ICM_SEL_RX_EVT_CLR) begin
         rx_ev.clr_bits = pwdata[ICM_RX_N-1:0];
      end
   end

   // context lines and masks feed the banks
   assign tx_ev.ctx_irq = tx_ctx_irq;
   assign rx_ev.ctx_irq = rx_ctx_irq;
   assign tx_ev.mask = tx_mask_r;
   assign rx_ev.mask = rx_irq_mask;

   ////////////////////////////////////////////////////////////////////////
   // event banks

   // eight tx contexts
   icm_event_bank #(
      .N(ICM_TX_N),
      .RST(ICM_TX_EVT_RST)
   ) u_tx_bank (
      .pclk(pclk),
      .presetn(presetn),
      .ev(tx_ev.bank)
   );

   // four rx contexts
   icm_event_bank #(
      .N(ICM_RX_N),
      .RST(ICM_RX_EVT_RST)
   ) u_rx_bank (
      .pclk(pclk),
      .presetn(presetn),
      .ev(rx_ev.bank)
   );

   ////////////////////////////////////////////////////////////////////////
   // tx mask register

   // set and clear sit at different offsets, so they never collide
   always_comb begin
      tx_mask_nxt = tx_mask_r;
      if (wr_go && sel == ICM_SEL_TX_MSK_SET) begin
         tx_mask_nxt = tx_mask_r | pwdata[ICM_TX_N-1:0];
      end else if (wr_go && sel == ICM_SEL_TX_MSK_CLR) begin
         tx_mask_nxt = tx_mask_r & ~pwdata[ICM_TX_N-1:0];
      end
   end

   // mask state; reset to zero so no tx context fires before software sets it up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_mask_r <= ICM_TX_MSK_RST;
      end else begin
         tx_mask_r <= tx_mask_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path

   // set offsets show raw state, event clear offsets show masked state
   always_comb begin
      rd_word = '0;
      unique case (sel)
         ICM_SEL_TX_EVT_SET: rd_word = icm_tx_word(tx_ev.event_q);
         ICM_SEL_TX_EVT_CLR: rd_word = icm_tx_word(tx_ev.masked);
         ICM_SEL_TX_MSK_SET: rd_word = icm_tx_word(tx_mask_r);
         ICM_SEL_TX_MSK_CLR: rd_word = icm_tx_word(tx_mask_r);
         ICM_SEL_RX_EVT_SET: rd_word = icm_rx_word(rx_ev.event_q);
         ICM_SEL_RX_EVT_CLR: rd_word = icm_rx_word(rx_ev.masked);
         ICM_SEL_NONE: rd_word = '0; // unmapped reads zero
      endcase
   end

   // stage read data at the setup edge; it holds through access
   // trade-off: a context edge during access is not seen in this read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (setup_ph && !pwrite) begin
         prdata_r <= rd_word;
      end
   end

   assign prdata = prdata_r;

   ////////////////////////////////////////////////////////////////////////
   // aggregate events and interrupt request

   // bit n of each bank contributes to its aggregate
   assign aggregate_tx_ctx_event = tx_ev.any;
   assign aggregate_rx_ctx_event = rx_ev.any;

   // request needs aggregate and main mask bit, and the global enable
   always_comb begin
      irq_req_nxt = main_irq_mask[ICM_GLOBAL_EN_BIT] &
                    ((tx_ev.any & main_irq_mask[ICM_MAIN_TX_BIT]) |
                     (rx_ev.any & main_irq_mask[ICM_MAIN_RX_BIT]));
   end

   // registered so the pin is glitch free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req_r <= 1'b0;
      end else begin
         irq_req_r <= irq_req_nxt;
      end
   end

   assign irq_req = irq_req_r;

endmodule

// ---- verilog/icm_pkg.sv ----
// constants and types for the iso context interrupt event and mask block
//
// Function
// - tx event bit per tx context
// - rx event bit per rx context
// - tx bit set by edge or set-write
// - rx bit set by edge or set-write
// - bits sticky, cleared only by one-writes
// - tx event at set 90h, clear 94h
// - tx clear read returns event and mask
// - rx event A0h/A4h, clear read masked
// - tx bit n feeds main bit 6
// - rx bit n feeds main bit 7
// - tx event and mask bits 31-8 zero
// - rx event bits 31-4 read zero
// - tx mask set 98h, clear 9Ch
// - mask reads return plain mask contents
// - mask bit n gates context n
// - tx request needs main bit 6 both
// - no request without global enable bit 31
package icm_pkg;

   // bus geometry
   localparam int ICM_ADDR_W = 8;
   localparam int ICM_DATA_W = 32;

   // context counts
   localparam int ICM_TX_N = 8;
   localparam int ICM_RX_N = 4;

   // register byte offsets
   localparam logic [7:0] ICM_TX_EVT_SET_OFS = 8'h90;
   localparam logic [7:0] ICM_TX_EVT_CLR_OFS = 8'h94;
   localparam logic [7:0] ICM_TX_MSK_SET_OFS = 8'h98;
   localparam logic [7:0] ICM_TX_MSK_CLR_OFS = 8'h9c;
   localparam logic [7:0] ICM_RX_EVT_SET_OFS = 8'ha0;
   localparam logic [7:0] ICM_RX_EVT_CLR_OFS = 8'ha4;

   // reset values of implemented bits (undefined in hardware, zero here)
   localparam logic [7:0] ICM_TX_EVT_RST = 8'h00;
   localparam logic [7:0] ICM_TX_MSK_RST = 8'h00;
   localparam logic [3:0] ICM_RX_EVT_RST = 4'h0;

   // bit positions in the main interrupt mask word
   localparam int ICM_MAIN_TX_BIT = 6;
   localparam int ICM_MAIN_RX_BIT = 7;
   localparam int ICM_GLOBAL_EN_BIT = 31;

   // one-hot register select
   typedef enum logic [6:0] {
      ICM_SEL_NONE = 7'h01,
      ICM_SEL_TX_EVT_SET = 7'h02,
      ICM_SEL_TX_EVT_CLR = 7'h04,
      ICM_SEL_TX_MSK_SET = 7'h08,
      ICM_SEL_TX_MSK_CLR = 7'h10,
      ICM_SEL_RX_EVT_SET = 7'h20,
      ICM_SEL_RX_EVT_CLR = 7'h40
   } icm_sel_t;

endpackage
